// file: pkg/srx_pkg.sv
// constants, frame entry layout and receiver states for the serial receiver
package srx_pkg;

  // ********************************************************
  // oversampling and sample positions
  // ********************************************************
  localparam logic [4:0] SRX_OVS_NORMAL = 5'h10; // samples per bit, normal speed
  localparam logic [4:0] SRX_OVS_DOUBLE = 5'h08; // samples per bit, double speed
  localparam logic [4:0] SRX_CNT_RESET  = 5'h01; // first zero sample of a start bit

  // ********************************************************
  // character size encoding
  // ********************************************************
  localparam logic [2:0] SRX_SIZE_9BIT  = 3'h7;  // nine data bits
  localparam logic [3:0] SRX_MIN_BITS   = 4'h5;  // size code 0 gives five bits
  localparam logic [3:0] SRX_BITS_8     = 4'h8;  // reserved codes fall back to eight
  localparam logic [3:0] SRX_BITS_9     = 4'h9;

  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [2:0] SRX_SYNC_RESET = 3'h7;  // pins idle high
  localparam logic [8:0] SRX_SHIFT_RESET = 9'h000;

  // one buffered frame: data, ninth bit and its own error flags
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
    logic       frame_err;
    logic       overrun;
    logic       parity_err;
  } srx_entry_t;

  // receiver sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_START  = 5'h02,
    ST_DATA   = 5'h04,
    ST_PARITY = 5'h08,
    ST_STOP   = 5'h10
  } srx_state_t;

endpackage

// file: core/srx_receiver.sv
// serial frame receiver with two-entry receive buffer and per-frame flags
`timescale 1ns/10ps
module srx_receiver
  import srx_pkg::*;
(
  input  wire logic       SYS_CLK,
  input  wire logic       RESET_N,
  input  wire logic       RX_ENABLE,
  input  wire logic       SYNC_MODE,
  input  wire logic       DOUBLE_SPEED,
  input  wire logic [2:0] CHAR_SIZE,
  input  wire logic       PARITY_ENABLE,
  input  wire logic       PARITY_ODD,
  input  wire logic       RXC_IRQ_ENABLE,
  input  wire logic       BAUD_TICK,
  input  wire logic       SERIAL_IN,
  input  wire logic       XFER_CLK_IN,
  input  wire logic       DATA_READ,
  output logic            PIN_OVERRIDE,
  output logic [7:0]      RX_DATA,
  output logic            NINTH_BIT,
  output logic            FRAME_ERROR,
  output logic            OVERRUN,
  output logic            PARITY_ERROR,
  output logic            RX_COMPLETE,
  output logic            RX_IRQ
);
  // ********************************************************
  // pin synchronisers
  // ********************************************************
  logic [2:0] rxd_sync, next_rxd_sync;
  logic [2:0] xck_sync, next_xck_sync;
  logic       line, next_line;
  logic       xck_lvl, next_xck_lvl;
  logic       xck_prev;

  // a level counts only once stages two and three agree
  always_comb begin
    next_rxd_sync = {rxd_sync[1:0], SERIAL_IN};
    next_xck_sync = {xck_sync[1:0], XFER_CLK_IN};
    next_line     = (rxd_sync[2] == rxd_sync[1]) ? rxd_sync[2] : line;
    next_xck_lvl  = (xck_sync[2] == xck_sync[1]) ? xck_sync[2] : xck_lvl;
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rxd_sync <= SRX_SYNC_RESET;
      xck_sync <= SRX_SYNC_RESET;
      line     <= 1'b1;
      xck_lvl  <= 1'b1;
      xck_prev <= 1'b1;
    end else begin
      rxd_sync <= next_rxd_sync;
      xck_sync <= next_xck_sync;
      line     <= next_line;
      xck_lvl  <= next_xck_lvl;
      xck_prev <= xck_lvl;
    end
  end

  // ********************************************************
  // bit sampling and sequencer
  // ********************************************************
  srx_state_t state, next_state;
  logic [4:0] cnt, next_cnt;
  logic [1:0] smp, next_smp;
  logic [8:0] shreg, next_shreg;
  logic [3:0] bit_idx, next_bit_idx;
  logic       par_bit, next_par_bit;
  logic       armed, next_armed;
  srx_entry_t hold, next_hold;
  logic       hold_valid, next_hold_valid;
  logic       ovr_pend, next_ovr_pend;
  logic       v0, next_v0;
  logic       v1, next_v1;
  logic       buf_ready, push, start_det;
  logic [4:0] ovs, mid, snum;
  logic [3:0] nbits;
  logic       xck_rise, decide, vote;
  logic [8:0] aligned;
  // decision point and bit value, async or on the transfer clock
  always_comb begin
    ovs      = DOUBLE_SPEED ? SRX_OVS_DOUBLE : SRX_OVS_NORMAL;
    mid      = ovs >> 1;
    snum     = (cnt == ovs) ? SRX_CNT_RESET : cnt + 5'h01;
    xck_rise = xck_lvl && !xck_prev;
    case (CHAR_SIZE)
      3'h0, 3'h1, 3'h2, 3'h3: nbits = SRX_MIN_BITS + {1'b0, CHAR_SIZE};
      SRX_SIZE_9BIT:          nbits = SRX_BITS_9;
      default:                nbits = SRX_BITS_8;
    endcase
    if (SYNC_MODE) begin
      decide = xck_rise && (state != ST_IDLE);
      vote   = line;
    end else begin
      decide = BAUD_TICK && (state != ST_IDLE) && (snum == mid + 5'h02);
      vote   = (smp[1] & smp[0]) | (smp[1] & line) | (smp[0] & line);
    end
    // frame sits at the top of the shift register; move it down
    aligned = shreg >> (4'h9 - nbits);
  end

  assign buf_ready = !(v0 && v1);
  assign push      = hold_valid && buf_ready;

  // sequencer, hold register and overrun tracking
  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_smp        = smp;
    next_shreg      = shreg;
    next_bit_idx    = bit_idx;
    next_par_bit    = par_bit;
    next_armed      = armed;
    next_hold       = hold;
    next_hold_valid = hold_valid && !push;
    next_ovr_pend   = ovr_pend;
    start_det       = 1'b0;
    if (push) next_ovr_pend = 1'b0;
    if (!SYNC_MODE && BAUD_TICK) begin
      next_cnt = snum;
      if (snum == mid || snum == mid + 5'h01) next_smp = {smp[0], line};
    end
    case (state)
      ST_IDLE: begin
        if (line) next_armed = 1'b1;
        if (SYNC_MODE && xck_rise && !line) begin
          start_det    = 1'b1;
          next_state   = ST_DATA;
          next_bit_idx = 4'h0;
        end else if (!SYNC_MODE && BAUD_TICK && armed && !line) begin
          start_det  = 1'b1;
          next_state = ST_START;
          next_cnt   = SRX_CNT_RESET;
        end
      end
      ST_START: begin
        if (decide) begin
          next_state   = vote ? ST_IDLE : ST_DATA; // noise spike rejected
          next_armed   = 1'b0;
          next_bit_idx = 4'h0;
        end
      end
      ST_DATA: begin
        if (decide) begin
          next_shreg   = {vote, shreg[8:1]};
          next_bit_idx = bit_idx + 4'h1;
          if (bit_idx + 4'h1 == nbits) next_state = PARITY_ENABLE ? ST_PARITY : ST_STOP;
        end
      end
      ST_PARITY: begin
        if (decide) begin
          next_par_bit = vote;
          next_state   = ST_STOP;
        end
      end
      ST_STOP: begin
        // only the first stop bit is judged; a second one looks like idle
        if (decide) begin
          next_hold.ninth      = (nbits == SRX_BITS_9) && aligned[8];
          next_hold.data       = aligned[7:0];
          next_hold.frame_err  = !vote;
          next_hold.overrun    = 1'b0;
          next_hold.parity_err = PARITY_ENABLE && (^aligned ^ par_bit ^ PARITY_ODD);
          next_hold_valid      = 1'b1;
          next_state           = ST_IDLE;
          next_armed           = 1'b0;
          next_shreg           = SRX_SHIFT_RESET;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (start_det && !buf_ready && hold_valid) next_ovr_pend = 1'b1;
    // disable drops everything in flight at once
    if (!RX_ENABLE) begin
      next_state      = ST_IDLE;
      next_armed      = 1'b0;
      next_hold_valid = 1'b0;
      next_ovr_pend   = 1'b0;
      next_shreg      = SRX_SHIFT_RESET;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state      <= ST_IDLE;
      cnt        <= SRX_CNT_RESET;
      smp        <= 2'h3;
      shreg      <= SRX_SHIFT_RESET;
      bit_idx    <= 4'h0;
      par_bit    <= 1'b0;
      armed      <= 1'b0;
      hold       <= '0;
      hold_valid <= 1'b0;
      ovr_pend   <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      smp        <= next_smp;
      shreg      <= next_shreg;
      bit_idx    <= next_bit_idx;
      par_bit    <= next_par_bit;
      armed      <= next_armed;
      hold       <= next_hold;
      hold_valid <= next_hold_valid;
      ovr_pend   <= next_ovr_pend;
    end
  end

  // ********************************************************
  // two-entry receive buffer and outputs
  // ********************************************************
  srx_entry_t e0, next_e0;
  srx_entry_t e1, next_e1;
  srx_entry_t push_entry;
  logic       pop;

  // head entry is a flop so the flags seen are the ones of the next read
  always_comb begin
    push_entry         = hold;
    push_entry.overrun = ovr_pend;
    pop     = DATA_READ && v0;
    next_e0 = e0;
    next_e1 = e1;
    next_v0 = v0;
    next_v1 = v1;
    if (pop) begin
      next_e0 = e1;
      next_v0 = v1;
      next_e1 = '0;
      next_v1 = 1'b0;
    end
    if (push) begin
      if (!next_v0) begin
        next_e0 = push_entry;
        next_v0 = 1'b1;
      end else begin
        next_e1 = push_entry;
        next_v1 = 1'b1;
      end
    end
    if (!RX_ENABLE) begin
      next_e0 = '0;
      next_e1 = '0;
      next_v0 = 1'b0;
      next_v1 = 1'b0;
    end
  end

  // flags only come from entries, so no write path can reach them
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      e0           <= '0;
      e1           <= '0;
      v0           <= 1'b0;
      v1           <= 1'b0;
      RX_COMPLETE  <= 1'b0;
      RX_IRQ       <= 1'b0;
      PIN_OVERRIDE <= 1'b0;
    end else begin
      e0           <= next_e0;
      e1           <= next_e1;
      v0           <= next_v0;
      v1           <= next_v1;
      RX_COMPLETE  <= next_v0;
      RX_IRQ       <= next_v0 && RXC_IRQ_ENABLE;
      PIN_OVERRIDE <= RX_ENABLE;
    end
  end

  assign RX_DATA      = e0.data;
  assign NINTH_BIT    = e0.ninth;
  assign FRAME_ERROR  = e0.frame_err;
  assign OVERRUN      = e0.overrun;
  assign PARITY_ERROR = e0.parity_err;

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  sequence pop_two_s;
    v0 && v1 && DATA_READ && RX_ENABLE && !push;
  endsequence
  sequence stop_seen_s;
    (state == ST_STOP) && decide && RX_ENABLE;
  endsequence
  flush_on_off_a: assert property (!RX_ENABLE |=> !RX_COMPLETE && !v1)
    else $error("buffer not flushed on disable");
  irq_follow_a: assert property (RX_IRQ |-> RX_COMPLETE && $past(RXC_IRQ_ENABLE))
    else $error("interrupt request without complete flag");
  irq_hold_a: assert property ((RX_COMPLETE && RXC_IRQ_ENABLE && RX_ENABLE && !DATA_READ) |=> RX_IRQ)
    else $error("interrupt request dropped without a read");
  abort_idle_a: assert property (!RX_ENABLE |=> state == ST_IDLE && !hold_valid)
    else $error("frame not abandoned on disable");
  fe_stop_a: assert property (stop_seen_s |=> hold.frame_err == !$past(vote))
    else $error("frame error does not match stop bit");
  parity_off_a: assert property (stop_seen_s ##0 !PARITY_ENABLE |=> !hold.parity_err)
    else $error("parity error with checking disabled");
  short_zero_a: assert property (stop_seen_s ##0 (CHAR_SIZE == 3'h0) |=> hold.data[7:5] == 3'h0)
    else $error("upper bits of short character not zero");
  pop_adv_a: assert property (pop_two_s |=> RX_DATA == $past(e1.data) && OVERRUN == $past(e1.overrun))
    else $error("read did not advance to next entry");
  ovr_set_a: assert property ((start_det && !buf_ready && hold_valid && RX_ENABLE) |=> ovr_pend)
    else $error("overrun not recorded");
  ovr_clr_a: assert property ((push && RX_ENABLE) |=> !ovr_pend || $past(start_det))
    else $error("overrun not cleared on transfer");
  override_a: assert property (PIN_OVERRIDE == $past(RX_ENABLE))
    else $error("pin override does not follow enable");

endmodule

// file: test/srx_tx_model.sv
// remote serial transmitter model that drives the receive line
`timescale 1ns/10ps
module srx_tx_model (
  input  wire logic clk,
  input  wire logic double_speed,
  output logic      line,
  output logic      xclk
);
  // ********************************************************
  // frame generator
  // ********************************************************
  // line idles high, transfer clock stands still between frames
  initial begin
    line = 1'h1;
    xclk = 1'h0;
  end

  // one bit: async holds a whole bit time, sync pulses the clock mid-bit
  task automatic put_bit(input logic b, input logic sync);
    line <= b;
    repeat (sync ? 8 : (double_speed ? 32 : 64)) @(negedge clk);
    if (sync) begin
      xclk <= 1'h1;
      repeat (8) @(negedge clk);
      xclk <= 1'h0;
    end
  endtask

  // start, data lsb first, optional parity, one stop bit
  task automatic send(input logic [8:0] d, input int nbits, input logic par_en, input logic odd,
                      input logic bad_par, input logic stop, input logic sync);
    logic p;
    p = odd;
    put_bit(1'h0, sync);
    for (int i = 0; i < nbits; i++) begin
      put_bit(d[i], sync);
      p = p ^ d[i];
    end
    if (par_en) put_bit(p ^ bad_par, sync);
    put_bit(stop, sync);
    line <= 1'h1;
  endtask
endmodule

// file: test/serial_receiver_buffer_flags_tb.sv
// self-checking bench for the serial receiver and its buffer
`timescale 1ns/10ps
module serial_receiver_buffer_flags_tb;
  logic       sys_clk, reset_n, rx_enable, sync_mode, double_speed, parity_enable, parity_odd;
  logic       rxc_irq_enable, baud_tick, serial_in, xfer_clk_in, data_read;
  logic [2:0] char_size;
  logic [1:0] tick_div;
  logic       pin_override, ninth_bit, frame_error, overrun, parity_error, rx_complete, rx_irq;
  logic [7:0] rx_data;
  int         check_count, n_fail, cyc;

  srx_receiver i_dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .RX_ENABLE(rx_enable), .SYNC_MODE(sync_mode),
    .DOUBLE_SPEED(double_speed), .CHAR_SIZE(char_size), .PARITY_ENABLE(parity_enable),
    .PARITY_ODD(parity_odd), .RXC_IRQ_ENABLE(rxc_irq_enable), .BAUD_TICK(baud_tick),
    .SERIAL_IN(serial_in), .XFER_CLK_IN(xfer_clk_in), .DATA_READ(data_read),
    .PIN_OVERRIDE(pin_override), .RX_DATA(rx_data), .NINTH_BIT(ninth_bit), .FRAME_ERROR(frame_error),
    .OVERRUN(overrun), .PARITY_ERROR(parity_error), .RX_COMPLETE(rx_complete), .RX_IRQ(rx_irq));

  srx_tx_model i_tx (.clk(sys_clk), .double_speed(double_speed), .line(serial_in), .xclk(xfer_clk_in));

  // ********************************************************
  // clock, oversample tick and hang guard
  // ********************************************************
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  // tick every fourth cycle: 64 cycles a bit normal, 32 at double speed
  always @(negedge sys_clk) begin
    tick_div <= tick_div + 2'h1;
    baud_tick <= (tick_div == 2'h3);
  end

  // about 24 frames of 700 cycles are expected, so 40000 is ample
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ********************************************************
  // shared tasks
  // ********************************************************
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // flags and ninth bit are judged before the read that pops them; no flag is ever written
  task automatic pop_check(input logic [7:0] d, input logic n9, input logic fe, input logic ov, input logic pe);
    check("complete", 9'h001, {8'h00, rx_complete});
    check("data", {1'h0, d}, {1'h0, rx_data});
    check("ninth", {8'h00, n9}, {8'h00, ninth_bit});
    check("flags", {6'h00, fe, ov, pe}, {6'h00, frame_error, overrun, parity_error});
    data_read <= 1'h1;
    @(negedge sys_clk);
    data_read <= 1'h0;
    // idle cycle so back-to-back reads never drive the strobe twice in one step
    @(negedge sys_clk);
  endtask

  task automatic rx(input logic [8:0] d, input logic [2:0] sz, input logic pe, input logic bad,
                    input logic stop, input logic sync);
    char_size = sz;
    parity_enable = pe;
    sync_mode = sync;
    i_tx.send(d, (sz == 3'h7) ? 9 : ((sz > 3'h3) ? 8 : int'(sz) + 5), pe, parity_odd, bad, stop, sync);
    repeat (8) @(negedge sys_clk);
  endtask

  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_sizes;
    for (int s = 0; s < 8; s++) begin
      rx(9'h1A5, s[2:0], 1'h0, 1'h0, 1'h1, 1'h0);
      pop_check((s > 3) ? 8'hA5 : 8'hA5 & ((8'h01 << (s + 5)) - 8'h01), s == 7, 1'h0, 1'h0, 1'h0);
    end
    check("empty", 9'h000, {8'h00, rx_complete});
    $display("sizes test done");
  endtask

  task automatic t_parity;
    for (int k = 0; k < 4; k++) begin
      parity_odd = k[1];
      rx(9'h0B3, 3'h3, 1'h1, k[0], 1'h1, 1'h0);
      pop_check(8'hB3, 1'h0, 1'h0, 1'h0, k[0]);
    end
    $display("parity test done");
  endtask

  task automatic t_overrun;
    rx(9'h011, 3'h3, 1'h0, 1'h0, 1'h1, 1'h0);
    rx(9'h022, 3'h3, 1'h0, 1'h0, 1'h1, 1'h0);
    rx(9'h033, 3'h3, 1'h0, 1'h0, 1'h1, 1'h0);
    rx(9'h044, 3'h3, 1'h0, 1'h0, 1'h0, 1'h0);
    pop_check(8'h11, 1'h0, 1'h0, 1'h0, 1'h0);
    pop_check(8'h22, 1'h0, 1'h0, 1'h0, 1'h0);
    pop_check(8'h44, 1'h0, 1'h1, 1'h1, 1'h0);
    rx(9'h055, 3'h3, 1'h0, 1'h0, 1'h1, 1'h0);
    pop_check(8'h55, 1'h0, 1'h0, 1'h0, 1'h0);
    $display("overrun test done");
  endtask

  task automatic t_irq;
    rxc_irq_enable = 1'h1;
    rx(9'h066, 3'h3, 1'h0, 1'h0, 1'h1, 1'h0);
    check("irq", 9'h001, {8'h00, rx_irq});
    pop_check(8'h66, 1'h0, 1'h0, 1'h0, 1'h0);
    check("irq off", 9'h000, {8'h00, rx_irq});
    rx(9'h077, 3'h3, 1'h0, 1'h0, 1'h0, 1'h0);
    rxc_irq_enable = 1'h0;
    repeat (2) @(negedge sys_clk);
    check("irq masked", 9'h000, {8'h00, rx_irq});
    pop_check(8'h77, 1'h0, 1'h1, 1'h0, 1'h0);
    $display("irq test done");
  endtask

  task automatic t_enable;
    rx(9'h088, 3'h3, 1'h0, 1'h0, 1'h1, 1'h0);
    rx(9'h099, 3'h3, 1'h0, 1'h0, 1'h1, 1'h0);
    rx_enable = 1'h0;
    repeat (2) @(negedge sys_clk);
    check("flushed", 9'h000, {8'h00, rx_complete});
    check("pin freed", 9'h000, {8'h00, pin_override});
    rx(9'h0AA, 3'h3, 1'h0, 1'h0, 1'h1, 1'h0);
    check("no rx off", 9'h000, {8'h00, rx_complete});
    rx_enable = 1'h1;
    repeat (16) @(negedge sys_clk);
    check("pin taken", 9'h001, {8'h00, pin_override});
    $display("enable test done");
  endtask

  task automatic t_modes;
    double_speed = 1'h1;
    rx(9'h05C, 3'h3, 1'h0, 1'h0, 1'h1, 1'h0);
    pop_check(8'h5C, 1'h0, 1'h0, 1'h0, 1'h0);
    double_speed = 1'h0;
    rx(9'h1C3, 3'h7, 1'h0, 1'h0, 1'h1, 1'h1);
    pop_check(8'hC3, 1'h1, 1'h0, 1'h0, 1'h0);
    sync_mode = 1'h0;
    $display("modes test done");
  endtask

  // ********************************************************
  // closing report and main sequence
  // ********************************************************
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    {reset_n, rx_enable, sync_mode, double_speed, parity_enable, parity_odd} = 6'h00;
    {rxc_irq_enable, baud_tick, data_read, char_size, tick_div} = 8'h00;
    repeat (10) @(negedge sys_clk);
    reset_n = 1'h1;
    rx_enable = 1'h1;
    repeat (16) @(negedge sys_clk);
    t_sizes();
    t_parity();
    t_overrun();
    t_irq();
    t_enable();
    t_modes();
    tally_and_finish();
  end
endmodule
